// ---- rtl/dor_router.sv ----
// Our own choices: the AHB-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
// Function
// - one-bit input-8 polarity, default zero, immediate
// - output-1 selector 0..31, default 11, on restart
// - code zero no function, undefined codes reserved
// - code 1 follows drive ready
// - code 2 active on detected error
// - code 3 active while warning issued
// - code 4 active while motor rotating
// - zero-speed active when speed equals zero
// - speed mode, active when |speed-cmd| below threshold
// - position mode, done when error below threshold
// - position mode, near when error below near threshold
// - torque-limit active while torque clamped
// - speed-limit active while speed clamped
module dor_router (
  input  wire logic                     REF_CLK_I,
  input  wire logic                     ARST_N_I,
  input  wire logic                     RESTART_I,
  input  wire logic                     HSEL_I,
  input  wire logic [31:0]              HADDR_I,
  input  wire logic [1:0]               HTRANS_I,
  input  wire logic                     HWRITE_I,
  input  wire logic [2:0]               HSIZE_I,
  input  wire logic [31:0]              HWDATA_I,
  input  wire logic                     HREADY_I,
  output logic      [31:0]              HRDATA_O,
  output logic                          HREADYOUT_O,
  output logic                          HRESP_O,
  input  wire logic                     DRIVE_READY_I,
  input  wire logic                     DRIVE_ERROR_I,
  input  wire logic                     DRIVE_WARN_I,
  input  wire logic                     ROTATING_I,
  input  wire logic                     TORQUE_CLAMP_I,
  input  wire logic                     SPEED_CLAMP_I,
  input  wire logic signed [dor_pkg::VAL_W-1:0] SPEED_I,
  input  wire logic signed [dor_pkg::VAL_W-1:0] SPEED_CMD_I,
  input  wire logic signed [dor_pkg::ERR_W-1:0] POS_ERR_I,
  input  wire logic                     DI8_PIN_I,
  output logic                          DI8_ACTIVE_O,
  output logic                          DO1_O,
  output logic                          IRQ_O
);
  import dor_pkg::*;

  // ---------------------------------------------------------------
  // Input synchronisers
  // ---------------------------------------------------------------
  logic [1:0] di8_sync;
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      di8_sync <= 2'h0;
    end else begin
      di8_sync <= {di8_sync[0], DI8_PIN_I};
    end
  end

  // ---------------------------------------------------------------
  // Bus slave and registers
  // ---------------------------------------------------------------
  logic                 dph_valid, next_dph_valid;
  logic                 dph_write, next_dph_write;
  logic [7:0]           dph_addr, next_dph_addr;
  logic                 in8_pol, next_in8_pol;
  logic [SEL_W-1:0]     sel_pend, next_sel_pend;
  logic [SEL_W-1:0]     sel_act, next_sel_act;
  logic [VAL_W-1:0]     spd_thr, next_spd_thr;
  logic [ERR_W-1:0]     done_thr, next_done_thr;
  logic [ERR_W-1:0]     near_thr, next_near_thr;
  dor_mode_e            mode, next_mode;
  logic [IRQ_W-1:0]     irq_stat, next_irq_stat;
  logic [IRQ_W-1:0]     irq_mask, next_irq_mask;
  logic [31:0]          next_rdata;
  logic                 do1_raw;
  logic                 di8_act;
  logic                 do1_prev, next_do1_prev;
  logic                 di8_prev, next_di8_prev;
  logic [IRQ_W-1:0]     ev;

  logic                 addr_take;
  logic                 wr_pol, wr_sel, wr_spd, wr_done;
  logic                 wr_near, wr_mode, wr_clr, wr_mask;

  always_comb begin
    addr_take      = HSEL_I && HREADY_I && HTRANS_I[1];
    next_dph_valid = addr_take;
    next_dph_write = HWRITE_I;
    next_dph_addr  = HADDR_I[7:0];
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      dph_valid   <= 1'b0;
      dph_write   <= 1'b0;
      dph_addr    <= 8'h00;
    end else begin
      dph_valid   <= next_dph_valid;
      dph_write   <= next_dph_write;
      dph_addr    <= next_dph_addr;
    end
  end

  // ---------------------------------------------------------------
  // Write strobes of the data phase
  // ---------------------------------------------------------------
  always_comb begin
    wr_pol  = 1'b0;
    wr_sel  = 1'b0;
    wr_spd  = 1'b0;
    wr_done = 1'b0;
    wr_near = 1'b0;
    wr_mode = 1'b0;
    wr_clr  = 1'b0;
    wr_mask = 1'b0;
    // Writes to read-only or unmapped words are dropped
    if (dph_valid && dph_write) begin
      unique case (dph_addr)
        ADDR_IN8_POL:      wr_pol  = 1'b1;
        ADDR_OUT1_SEL:     wr_sel  = 1'b1;
        ADDR_SPD_THR:      wr_spd  = 1'b1;
        ADDR_POS_DONE_THR: wr_done = 1'b1;
        ADDR_POS_NEAR_THR: wr_near = 1'b1;
        ADDR_CTRL_MODE:    wr_mode = 1'b1;
        ADDR_IRQ_STATUS:   wr_clr  = 1'b1;
        ADDR_IRQ_MASK:     wr_mask = 1'b1;
        default:           wr_pol  = 1'b0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Configuration registers
  // ---------------------------------------------------------------
  always_comb begin
    next_in8_pol  = wr_pol  ? HWDATA_I[0]         : in8_pol;
    next_sel_pend = wr_sel  ? HWDATA_I[SEL_W-1:0] : sel_pend;
    next_spd_thr  = wr_spd  ? HWDATA_I[VAL_W-1:0] : spd_thr;
    next_done_thr = wr_done ? HWDATA_I            : done_thr;
    next_near_thr = wr_near ? HWDATA_I            : near_thr;
    next_mode     = wr_mode ? dor_mode_e'(HWDATA_I[1:0]) : mode;
    next_irq_mask = wr_mask ? HWDATA_I[IRQ_W-1:0] : irq_mask;
    // Selector change reaches the output only on restart
    next_sel_act  = RESTART_I ? sel_pend : sel_act;
  end

  // ---------------------------------------------------------------
  // Interrupt status
  // ---------------------------------------------------------------
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_clr) begin
      next_irq_stat = irq_stat & ~HWDATA_I[IRQ_W-1:0];
    end
    // A new event wins over a clear in the same cycle
    next_irq_stat = next_irq_stat | ev;
  end

  // ---------------------------------------------------------------
  // Read data, formed in the address phase
  // ---------------------------------------------------------------
  always_comb begin
    next_rdata = HRDATA_O;
    // Unmapped words read as zero
    if (addr_take && !HWRITE_I) begin
      unique case (HADDR_I[7:0])
        ADDR_IN8_POL:      next_rdata = {31'h0, in8_pol};
        ADDR_OUT1_SEL:     next_rdata = {27'h0, sel_pend};
        ADDR_OUT1_ACTIVE:  next_rdata = {27'h0, sel_act};
        ADDR_STATUS_IN:    next_rdata = {30'h0, di8_act, do1_raw};
        ADDR_SPD_THR:      next_rdata = {16'h0, spd_thr};
        ADDR_POS_DONE_THR: next_rdata = done_thr;
        ADDR_POS_NEAR_THR: next_rdata = near_thr;
        ADDR_CTRL_MODE:    next_rdata = {30'h0, mode};
        ADDR_IRQ_STATUS:   next_rdata = {29'h0, irq_stat};
        ADDR_IRQ_MASK:     next_rdata = {29'h0, irq_mask};
        default:           next_rdata = 32'h0;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      in8_pol     <= IN8_POL_RST;
      sel_pend    <= OUT1_SEL_RST;
      sel_act     <= OUT1_SEL_RST;
      spd_thr     <= SPD_THR_RST;
      done_thr    <= POS_THR_RST;
      near_thr    <= NEAR_THR_RST;
      mode        <= DOR_MODE_POS;
      irq_stat    <= '0;
      irq_mask    <= '0;
      HRDATA_O    <= 32'h0;
    end else begin
      in8_pol     <= next_in8_pol;
      sel_pend    <= next_sel_pend;
      sel_act     <= next_sel_act;
      spd_thr     <= next_spd_thr;
      done_thr    <= next_done_thr;
      near_thr    <= next_near_thr;
      mode        <= next_mode;
      irq_stat    <= next_irq_stat;
      irq_mask    <= next_irq_mask;
      HRDATA_O    <= next_rdata;
    end
  end

  // ---------------------------------------------------------------
  // Status conditions
  // ---------------------------------------------------------------
  logic [VAL_W:0] spd_diff;
  logic [VAL_W:0] spd_abs;
  logic [ERR_W:0] err_abs;
  logic           zero_spd, spd_match, pos_done, pos_near;

  always_comb begin
    spd_diff  = {SPEED_I[VAL_W-1], SPEED_I}
              - {SPEED_CMD_I[VAL_W-1], SPEED_CMD_I};
    spd_abs   = spd_diff[VAL_W] ? (~spd_diff + 1'b1) : spd_diff;
    err_abs   = POS_ERR_I[ERR_W-1]
              ? (~{1'b1, POS_ERR_I} + 1'b1) : {1'b0, POS_ERR_I};
    zero_spd  = (SPEED_I == '0);
    spd_match = (mode == DOR_MODE_SPD)
             && (spd_abs < {1'b0, spd_thr});
    pos_done  = (mode == DOR_MODE_POS)
             && (err_abs < {1'b0, done_thr});
    pos_near  = (mode == DOR_MODE_POS)
             && (err_abs < {1'b0, near_thr});
  end

  // ---------------------------------------------------------------
  // Input 8 polarity
  // ---------------------------------------------------------------
  always_comb begin
    di8_act = in8_pol ? di8_sync[1] : !di8_sync[1];
  end

  // ---------------------------------------------------------------
  // Output function selector
  // ---------------------------------------------------------------
  always_comb begin
    unique case (sel_act)
      FN_READY:     do1_raw = DRIVE_READY_I;
      FN_ERROR:     do1_raw = DRIVE_ERROR_I;
      FN_WARN:      do1_raw = DRIVE_WARN_I;
      FN_ROTATE:    do1_raw = ROTATING_I;
      FN_ZERO_SPD:  do1_raw = zero_spd;
      FN_SPD_MATCH: do1_raw = spd_match;
      FN_POS_DONE:  do1_raw = pos_done;
      FN_POS_NEAR:  do1_raw = pos_near;
      FN_TRQ_LIM:   do1_raw = TORQUE_CLAMP_I;
      FN_SPD_LIM:   do1_raw = SPEED_CLAMP_I;
      default:      do1_raw = 1'b0;
    endcase
  end

  // ---------------------------------------------------------------
  // Event edges
  // ---------------------------------------------------------------
  always_comb begin
    next_do1_prev = do1_raw;
    next_di8_prev = di8_act;
    ev = '0;
    ev[IRQ_OUT_RISE] = do1_raw && !do1_prev;
    ev[IRQ_OUT_FALL] = !do1_raw && do1_prev;
    ev[IRQ_IN8_ACT]  = di8_act && !di8_prev;
  end

  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      do1_prev <= 1'b0;
      // Idle pin with low-active polarity reads active: no false edge
      di8_prev <= 1'b1;
    end else begin
      do1_prev <= next_do1_prev;
      di8_prev <= next_di8_prev;
    end
  end

  // ---------------------------------------------------------------
  // Output registers
  // ---------------------------------------------------------------
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      DO1_O        <= 1'b0;
      DI8_ACTIVE_O <= 1'b0;
      IRQ_O        <= 1'b0;
      HREADYOUT_O  <= 1'b1;
      HRESP_O      <= 1'b0;
    end else begin
      DO1_O        <= do1_raw;
      DI8_ACTIVE_O <= di8_act;
      IRQ_O        <= |(next_irq_stat & irq_mask);
      HREADYOUT_O  <= 1'b1;
      HRESP_O      <= 1'b0;
    end
  end

endmodule

// ---- rtl/dor_pkg.sv ----
package dor_pkg;

  // ---------------------------------------------------------------
  // Register map (byte addresses)
  // ---------------------------------------------------------------
  localparam logic [7:0] ADDR_IN8_POL      = 8'h00;
  localparam logic [7:0] ADDR_OUT1_SEL     = 8'h04;
  localparam logic [7:0] ADDR_OUT1_ACTIVE  = 8'h08;
  localparam logic [7:0] ADDR_STATUS_IN    = 8'h0c;
  localparam logic [7:0] ADDR_SPD_THR      = 8'h10;
  localparam logic [7:0] ADDR_POS_DONE_THR = 8'h14;
  localparam logic [7:0] ADDR_POS_NEAR_THR = 8'h18;
  localparam logic [7:0] ADDR_CTRL_MODE    = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STATUS   = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK     = 8'h24;

  // ---------------------------------------------------------------
  // Reset values and widths
  // ---------------------------------------------------------------
  localparam int         SEL_W         = 5;
  localparam int         VAL_W         = 16;
  localparam int         ERR_W         = 32;
  localparam logic       IN8_POL_RST   = 1'h0;
  localparam logic [4:0] OUT1_SEL_RST  = 5'h0b;
  localparam logic [15:0] SPD_THR_RST  = 16'h000a;
  localparam logic [31:0] POS_THR_RST  = 32'h0000_0007;
  localparam logic [31:0] NEAR_THR_RST = 32'h0000_0007;

  // ---------------------------------------------------------------
  // Output function codes
  // ---------------------------------------------------------------
  localparam logic [4:0] FN_NONE      = 5'h00;
  localparam logic [4:0] FN_READY     = 5'h01;
  localparam logic [4:0] FN_ERROR     = 5'h02;
  localparam logic [4:0] FN_WARN      = 5'h03;
  localparam logic [4:0] FN_ROTATE    = 5'h04;
  localparam logic [4:0] FN_ZERO_SPD  = 5'h05;
  localparam logic [4:0] FN_SPD_MATCH = 5'h06;
  localparam logic [4:0] FN_POS_DONE  = 5'h07;
  localparam logic [4:0] FN_POS_NEAR  = 5'h08;
  localparam logic [4:0] FN_TRQ_LIM   = 5'h09;
  localparam logic [4:0] FN_SPD_LIM   = 5'h0a;

  // Control modes
  typedef enum logic [1:0] {
    DOR_MODE_POS = 2'h0,
    DOR_MODE_SPD = 2'h1,
    DOR_MODE_TRQ = 2'h2
  } dor_mode_e;

  // Interrupt status bits
  localparam int IRQ_OUT_RISE = 0;
  localparam int IRQ_OUT_FALL = 1;
  localparam int IRQ_IN8_ACT  = 2;
  localparam int IRQ_W        = 3;

endpackage

// ---- tb/dor_router_chk.sv ----
`timescale 1ns/1ps
module dor_router_chk (
  input wire logic                              REF_CLK_I,
  input wire logic                              ARST_N_I,
  input wire logic                              RESTART_I,
  input wire logic                              HSEL_I,
  input wire logic [31:0]                       HADDR_I,
  input wire logic [1:0]                        HTRANS_I,
  input wire logic                              HWRITE_I,
  input wire logic [31:0]                       HWDATA_I,
  input wire logic                              HREADY_I,
  input wire logic                              DRIVE_READY_I,
  input wire logic                              DRIVE_ERROR_I,
  input wire logic                              DRIVE_WARN_I,
  input wire logic                              ROTATING_I,
  input wire logic                              TORQUE_CLAMP_I,
  input wire logic signed [dor_pkg::VAL_W-1:0]  SPEED_I,
  input wire logic                              DI8_PIN_I,
  input wire logic                              DI8_ACTIVE_O,
  input wire logic                              DO1_O
);
  import dor_pkg::*;
  // ----------------------------------------------
  // Shadow copies of polarity and selectors
  // ----------------------------------------------
  logic       wr_sel, wr_pol, pol;
  logic [4:0] pend, act;
  wire        take = HSEL_I && HREADY_I && HTRANS_I[1] && HWRITE_I;
  always_ff @(posedge REF_CLK_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      wr_sel <= 1'b0;
      wr_pol <= 1'b0;
      pol    <= IN8_POL_RST;
      pend   <= OUT1_SEL_RST;
      act    <= OUT1_SEL_RST;
    end else begin
      wr_sel <= take && HADDR_I[7:0] == ADDR_OUT1_SEL;
      wr_pol <= take && HADDR_I[7:0] == ADDR_IN8_POL;
      if (wr_sel) pend <= HWDATA_I[4:0];
      if (wr_pol) pol <= HWDATA_I[0];
      if (RESTART_I) act <= pend;
    end
  end
  default clocking @(posedge REF_CLK_I); endclocking
  default disable iff (!ARST_N_I);
  a_in8_level: assert property (
    ($stable(DI8_PIN_I) && $stable(pol)) [*4] |->
    DI8_ACTIVE_O == (DI8_PIN_I == pol)) else $error("input 8 level");
  a_reserved_low: assert property (
    ($past(act) == FN_NONE || $past(act) > FN_SPD_LIM) |-> !DO1_O)
    else $error("reserved code drives output");
  a_ready_out: assert property (
    $past(act) == FN_READY |-> DO1_O == $past(DRIVE_READY_I))
    else $error("ready output");
  a_error_out: assert property (
    $past(act) == FN_ERROR |-> DO1_O == $past(DRIVE_ERROR_I))
    else $error("error output");
  a_warn_out: assert property (
    $past(act) == FN_WARN |-> DO1_O == $past(DRIVE_WARN_I))
    else $error("warning output");
  a_rotate_out: assert property (
    $past(act) == FN_ROTATE |-> DO1_O == $past(ROTATING_I))
    else $error("rotation output");
  a_zero_speed: assert property (
    $past(act) == FN_ZERO_SPD |-> DO1_O == ($past(SPEED_I) == 16'sh0))
    else $error("zero speed output");
  a_torque_clamp: assert property (
    $past(act) == FN_TRQ_LIM |-> DO1_O == $past(TORQUE_CLAMP_I))
    else $error("torque limit output");
endmodule

// ---- tb/dor_ctrl_model.sv ----
`timescale 1ns/1ps
module dor_ctrl_model (
  input  wire logic clk_i,
  input  wire logic rst_n_i,
  input  wire logic do1_i,
  input  wire logic level_i,
  output logic      pin_o,
  output logic      seen_o
);
  // Controller samples the output terminal once a cycle
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) seen_o <= 1'b0;
    else seen_o <= do1_i;
  end
  // Contact drives the input terminal continuously
  assign pin_o = level_i;
endmodule

// ---- tb/dor_router_tb.sv ----
`timescale 1ns/1ps
`define DOR_CHK(g, e) begin \
  cmp_count++; \
  if ((g) !== (e)) begin \
    n_mismatch++; \
    $display("wrong value t=%0t got %h exp %h", $time, g, e); \
  end \
end
module dor_router_tb;
  import dor_pkg::*;
  logic                    clk = 1'b0, rst_n = 1'b0, restart = 1'b0;
  logic                    hsel = 1'b0, hwrite = 1'b0, lvl = 1'b0;
  logic [1:0]              htrans = 2'h0;
  logic [31:0]             haddr = 32'h0, hwdata = 32'h0, rd;
  logic                    rdy = 1'b0, err = 1'b0, wrn = 1'b0;
  logic                    rot = 1'b0, tcl = 1'b0, scl = 1'b0;
  logic signed [VAL_W-1:0] spd = 16'sh1, cmd = 16'sh7000;
  logic signed [ERR_W-1:0] perr = 32'sh100;
  wire  [31:0]             hrdata;
  wire                     hready, hresp, pin, di8_act, do1, irq, seen;
  int                      n_mismatch = 0, cmp_count = 0, cyc = 0, prv = 11;
  int                      codes[13] = '{0, 1, 2, 3, 4, 5, 6, 7, 8, 9, 10, 11, 31};
  always #10 clk = ~clk;
  dor_router dor_router_i (.REF_CLK_I(clk), .ARST_N_I(rst_n),
    .RESTART_I(restart), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'h2), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .DRIVE_READY_I(rdy), .DRIVE_ERROR_I(err), .DRIVE_WARN_I(wrn),
    .ROTATING_I(rot), .TORQUE_CLAMP_I(tcl), .SPEED_CLAMP_I(scl),
    .SPEED_I(spd), .SPEED_CMD_I(cmd), .POS_ERR_I(perr), .DI8_PIN_I(pin),
    .DI8_ACTIVE_O(di8_act), .DO1_O(do1), .IRQ_O(irq));
  dor_ctrl_model dor_ctrl_model_i (.clk_i(clk), .rst_n_i(rst_n),
    .do1_i(do1), .level_i(lvl), .pin_o(pin), .seen_o(seen));
  // ----------------------------------------------
  // Bus cycles and stimulus helpers
  // ----------------------------------------------
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
    // Idle cycle so a following read sees the write
    @(posedge clk);
  endtask
  task automatic rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    `DOR_CHK(rd, e)
  endtask
  task automatic pulse();
    @(posedge clk);
    restart <= 1'b1;
    @(posedge clk);
    restart <= 1'b0;
  endtask
  // Raise the condition of code c (code 7 also raises near); reserved codes raise all but speed match
  task automatic cond(input int c, input logic on);
    logic x;
    x = on && (c == 0 || c > 10);
    rdy <= x || (on && c == 1);
    err <= x || (on && c == 2);
    wrn <= x || (on && c == 3);
    rot <= x || (on && c == 4);
    tcl <= x || (on && c == 9);
    scl <= x || (on && c == 10);
    spd <= (c == 6) ? 16'sd100 : ((x || (on && c == 5)) ? 16'sd0 : 16'sd1);
    cmd <= (c != 6) ? 16'sh7000 : (on ? 16'sd95 : 16'sd90);
    perr <= (c == 7) ? (on ? 32'sd6 : 32'sd7) :
            (c == 8) ? (on ? 32'sd19 : 32'sd20) : (x ? 32'sd0 : 32'sh100);
  endtask
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_mismatch++;
      end_sim();
    end
  end
  initial begin
    logic e;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    rchk(ADDR_IN8_POL, 32'h0);
    rchk(ADDR_OUT1_SEL, 32'hb);
    rchk(ADDR_IRQ_MASK, 32'h0);
    rchk(ADDR_IRQ_STATUS, 32'h0);
    `DOR_CHK(hresp, 1'b0)
    rchk(8'h30, 32'h0);
    `DOR_CHK(di8_act, 1'b1)
    bus(1'b1, ADDR_IN8_POL, 32'h1);
    repeat (2) @(posedge clk);
    `DOR_CHK(di8_act, 1'b0)
    lvl <= 1'b1;
    repeat (5) @(posedge clk);
    `DOR_CHK(di8_act, 1'b1)
    bus(1'b1, ADDR_POS_NEAR_THR, 32'h14);
    for (int i = 0; i < 13; i++) begin
      bus(1'b1, ADDR_OUT1_SEL, 32'(codes[i]));
      bus(1'b1, ADDR_CTRL_MODE, {31'h0, codes[i] == 6});
      rchk(ADDR_OUT1_ACTIVE, 32'(prv));
      pulse();
      prv = codes[i];
      for (int k = 0; k < 2; k++) begin
        cond(codes[i], k == 1);
        e = (k == 1) && codes[i] >= 1 && codes[i] <= 10;
        repeat (3) @(posedge clk);
        `DOR_CHK(do1, e)
        `DOR_CHK(seen, e)
      end
    end
    bus(1'b1, ADDR_OUT1_SEL, 32'h4);
    pulse();
    cond(4, 1'b0);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h7);
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    `DOR_CHK(irq, 1'b0)
    cond(4, 1'b1);
    repeat (3) @(posedge clk);
    `DOR_CHK(irq, 1'b1)
    rchk(ADDR_IRQ_STATUS, 32'h1);
    bus(1'b1, ADDR_IRQ_MASK, 32'h0);
    @(posedge clk);
    `DOR_CHK(irq, 1'b0)
    bus(1'b1, ADDR_IRQ_MASK, 32'h1);
    bus(1'b1, ADDR_IRQ_STATUS, 32'h1);
    repeat (2) @(posedge clk);
    `DOR_CHK(irq, 1'b0)
    end_sim();
  end
endmodule
bind dor_router dor_router_chk dor_router_chk_i (.REF_CLK_I(REF_CLK_I),
  .ARST_N_I(ARST_N_I), .RESTART_I(RESTART_I), .HSEL_I(HSEL_I),
  .HADDR_I(HADDR_I), .HTRANS_I(HTRANS_I), .HWRITE_I(HWRITE_I),
  .HWDATA_I(HWDATA_I), .HREADY_I(HREADY_I), .DRIVE_READY_I(DRIVE_READY_I),
  .DRIVE_ERROR_I(DRIVE_ERROR_I), .DRIVE_WARN_I(DRIVE_WARN_I),
  .ROTATING_I(ROTATING_I), .TORQUE_CLAMP_I(TORQUE_CLAMP_I),
  .SPEED_I(SPEED_I), .DI8_PIN_I(DI8_PIN_I), .DI8_ACTIVE_O(DI8_ACTIVE_O),
  .DO1_O(DO1_O));
